// ==== design/jog_defs.svh ====
// Constants for the joystick jog and analogue output block.
`ifndef JOG_DEFS_SVH
`define JOG_DEFS_SVH
// ----
// Widths
// ----
`define ADC_W        12
`define DAC_W        12
`define VAL_W        16
`define SEL_W        7
`define CH_W         4
`define ADC_N        5
// ----
// Channel numbers and sample indices
// ----
`define CH_DAC1      4'h1
`define CH_DAC2      4'h2
`define CH_ADC_FIRST 4'h1
`define CH_ADC_LAST  4'h5
`define CH_BIPOLAR   4'h2
`define IDX_STICK    3'h2
`define IDX_CT       3'h4
// ----
// Value limits
// ----
`define DAC_POS_MAX  16'sh07FF
`define DAC_NEG_MAX  16'shF801
`define CENTER_TAP   12'h000
// ----
// Jog source pattern bit that enables stick jogging (0100000)
// ----
`define SEL_STICK    5
// ----
// Reset values
// ----
`define RST_DAC      12'h000
`define RST_CENTER   12'h000
`define RST_BAND     12'h000
`define RST_RANGE    12'h000
`define RST_SPEED    16'h0000
`define RST_SEL      7'h00
`endif

// ==== design/jog_pkg.sv ====
// Types shared by the joystick jog and analogue output block.
`include "jog_defs.svh"
package jog_pkg;
    // Host command operations.
    typedef enum logic [3:0] {
        op_set_analog_output = 4'b0000,
        op_read_analog_input = 4'b0001,
        op_set_center        = 4'b0010,
        op_set_dead_band     = 4'b0011,
        op_set_range         = 4'b0100,
        op_set_max_speed     = 4'b0101,
        op_set_jog_source    = 4'b0110,
        op_query_settings    = 4'b0111,
        op_backup            = 4'b1000
    } cmd_op_e;
    // Reply kinds.
    typedef enum logic [2:0] {
        reply_ok       = 3'b000,
        reply_value    = 3'b001,
        reply_settings = 3'b010,
        reply_bad_dac  = 3'b011,
        reply_bad_adc  = 3'b100
    } reply_code_e;
    // Front panel indicator codes.
    typedef enum logic [1:0] {
        status_idle  = 2'b00,
        status_stick = 2'b01
    } status_e;
    // Whole state of the top module.
    typedef struct packed {
        logic [`ADC_N-1:0][`ADC_W-1:0] adc_s1;
        logic [`ADC_N-1:0][`ADC_W-1:0] adc_s2;
        logic [`DAC_W-1:0]             dac1_gp;
        logic [`DAC_W-1:0]             dac1_out;
        logic [`DAC_W-1:0]             dac2;
        logic [`ADC_W-1:0]             center;
        logic [`ADC_W-1:0]             dead_band;
        logic [`ADC_W-1:0]             range;
        logic [`VAL_W-1:0]             max_speed;
        logic [`SEL_W-1:0]             jog_sel;
        logic                          reply_valid;
        reply_code_e                   reply_code;
        logic [`VAL_W-1:0]             reply_data;
        logic                          backup_valid;
        logic                          jog_active;
        logic                          jog_dir;
        logic [`VAL_W-1:0]             jog_speed;
        status_e                       status;
    } state_s;
endpackage

// ==== design/jog_speed_calc.sv ====
// Dead band, linear scaling and speed limit of the stick jog.
`timescale 1ns/1ns
module jog_speed_calc #(
    parameter int ADC_W   = 12,
    parameter int SPEED_W = 16
) (
    input  wire logic [ADC_W-1:0]   stick,
    input  wire logic [ADC_W-1:0]   zero_ref,
    input  wire logic [ADC_W-1:0]   dead_band,
    input  wire logic [ADC_W-1:0]   range,
    input  wire logic [SPEED_W-1:0] max_speed,
    output logic                    moving,
    output logic                    dir,
    output logic [SPEED_W-1:0]      speed
);
    logic signed [ADC_W+1:0]      dev;
    logic        [ADC_W:0]        mag;
    logic        [ADC_W:0]        excess;
    logic        [ADC_W+SPEED_W:0] prod;

    // Signed deviation from the zero point; the sign gives direction.
    always_comb begin
        dev    = $signed({2'b00, stick}) - $signed({2'b00, zero_ref});
        dir    = dev[ADC_W+1];
        mag    = dir ? (ADC_W+1)'(-dev) : (ADC_W+1)'(dev);
        moving = mag > {1'b0, dead_band};
        excess = moving ? mag - {1'b0, dead_band} : '0;
        prod   = (ADC_W+SPEED_W+1)'(excess) * (ADC_W+SPEED_W+1)'(max_speed);
        // A zero range would divide by zero, so it means full speed at once.
        if (!moving) begin
            speed = '0;
        end else if (range == '0 || excess >= {1'b0, range}) begin
            speed = max_speed;
        end else begin
            // Range is set by the operator from the calibration readings.
            speed = SPEED_W'(prod / range);
        end
    end
endmodule // jog_speed_calc

// ==== design/joystick_jog_and_dac_output.sv ====
// Analogue outputs, input readback and joystick jog of one motion axis.
//
// What this block does
// - Each analogue output takes a signed value clamped to -2047..+2047 for a 12-bit DAC.
// - A set-output command loads the value into the chosen channel and answers OK.
// - A set-output command for a channel other than 1 or 2 changes nothing and answers an error.
// - In servo mode output 1 follows the servo loop, in stepper modes it holds the written value.
// - Stick deflection is sampled from input 3 and the centre tap from input 5.
// - A stored centre of zero selects the centre tap as zero point, otherwise the stored centre.
// - No jog starts while the deviation stays within the dead band.
// - Jog speed never exceeds the stored maximum speed in steps per second.
// - The jog source pattern 0100000 enables stick jogging.
// - The panel indicator shows one code while stick jogging and another while idle.
// - A query reports centre, threshold, range and speed, and a backup copies them to flash.
// - A read-input command returns the current converted value of that input.
// - Inputs 3 to 5 are unipolar readings from 0 to 4095.
// - A read-input command outside 1 to 5 answers an invalid channel error.
`timescale 1ns/1ns
module joystick_jog_and_dac_output (
    input  wire logic                      clk,
    input  wire logic                      rst_n,
    input  wire logic                      clk_en,

    // Command channel.
    input  wire logic                      cmd_valid,
    output logic                           cmd_ready,
    input  wire jog_pkg::cmd_op_e          cmd_op,
    input  wire logic [`CH_W-1:0]          cmd_channel,
    input  wire logic signed [`VAL_W-1:0]  cmd_value,

    // Reply channel.
    output logic                           reply_valid,
    output jog_pkg::reply_code_e           reply_code,
    output logic [`VAL_W-1:0]              reply_data,

    // Converter samples, asynchronous to clk.
    input  wire logic [`ADC_W-1:0]         adc_in1,
    input  wire logic [`ADC_W-1:0]         adc_in2,
    input  wire logic [`ADC_W-1:0]         adc_in3,
    input  wire logic [`ADC_W-1:0]         adc_in4,
    input  wire logic [`ADC_W-1:0]         center_tap_input,

    // Servo loop.
    input  wire logic                      servo_mode,
    input  wire logic signed [`VAL_W-1:0]  servo_drive,

    // Analogue outputs.
    output logic [`DAC_W-1:0]              dac_out1,
    output logic [`DAC_W-1:0]              dac_out2,

    // Stored stick settings.
    output logic [`ADC_W-1:0]              stick_center_value,
    output logic [`ADC_W-1:0]              stick_dead_band,
    output logic [`ADC_W-1:0]              stick_range_value,
    output logic [`VAL_W-1:0]              stick_max_speed,
    output logic [`SEL_W-1:0]              jog_source_select,
    output logic                           backup_to_flash_cmd,

    // Jog and panel.
    output logic                           jog_active,
    output logic                           jog_dir,
    output logic [`VAL_W-1:0]              jog_speed,
    output jog_pkg::status_e               status_code
);
    import jog_pkg::*;

    // ----
    // Reset image
    // ----
    localparam state_s RST_STATE = '{
        adc_s1:       '0,
        adc_s2:       '0,
        dac1_gp:      `RST_DAC,
        dac1_out:     `RST_DAC,
        dac2:         `RST_DAC,

        center:       `RST_CENTER,
        dead_band:    `RST_BAND,
        range:        `RST_RANGE,
        max_speed:    `RST_SPEED,
        jog_sel:      `RST_SEL,

        reply_valid:  1'b0,
        reply_code:   reply_ok,
        reply_data:   '0,

        backup_valid: 1'b0,

        jog_active:   1'b0,
        jog_dir:      1'b0,
        jog_speed:    '0,
        status:       status_idle
    };

    state_s                cur;
    state_s                next_cur;

    logic   [`ADC_W-1:0]   zero_ref;
    logic                  calc_moving;
    logic                  calc_dir;
    logic   [`VAL_W-1:0]   calc_speed;

    logic                  take;
    logic                  stick_on;

    // ----
    // Helpers
    // ----

    // Saturate a wide signed value to the DAC span.
    function automatic logic [`DAC_W-1:0] clamp_dac(input logic signed [`VAL_W-1:0] v);
        if (v > `DAC_POS_MAX) begin
            clamp_dac = `DAC_W'(`DAC_POS_MAX);
        end else if (v < `DAC_NEG_MAX) begin
            clamp_dac = `DAC_W'(`DAC_NEG_MAX);
        end else begin
            clamp_dac = v[`DAC_W-1:0];
        end
    endfunction

    // Readback of one synchronised sample as a 16-bit reply word.
    function automatic logic [`VAL_W-1:0] adc_word(
        input logic [`ADC_N-1:0][`ADC_W-1:0] s,
        input logic [`CH_W-1:0]              ch
    );
        logic [`ADC_W-1:0] raw;

        raw = s[3'(ch - `CH_ADC_FIRST)];
        if (ch <= `CH_BIPOLAR) begin
            // Bipolar inputs are two's complement, so sign extend.
            adc_word = {{(`VAL_W-`ADC_W){raw[`ADC_W-1]}}, raw};
        end else begin
            adc_word = {{(`VAL_W-`ADC_W){1'b0}}, raw};
        end
    endfunction

    // ----
    // Jog speed
    // ----

    // A stored centre of zero means the centre tap provides the zero point.
    // A stick without a centre tap therefore needs a non-zero stored centre.
    always_comb begin
        if (cur.center == `CENTER_TAP) begin
            zero_ref = cur.adc_s2[`IDX_CT];
        end else begin
            zero_ref = cur.center;
        end
    end

    jog_speed_calc #(
        .ADC_W   (`ADC_W),
        .SPEED_W (`VAL_W)
    ) u_speed (
        .stick     (cur.adc_s2[`IDX_STICK]),
        .zero_ref  (zero_ref),
        .dead_band (cur.dead_band),
        .range     (cur.range),
        .max_speed (cur.max_speed),
        .moving    (calc_moving),
        .dir       (calc_dir),
        .speed     (calc_speed)
    );

    // Commands are taken in one cycle, so ready only follows the enable.
    assign cmd_ready = clk_en;
    assign take      = cmd_valid & clk_en;
    assign stick_on  = cur.jog_sel[`SEL_STICK];

    // ----
    // Next state
    // ----
    always_comb begin
        next_cur = cur;

        // Converter words are only trusted after two flops.
        next_cur.adc_s1 = {center_tap_input, adc_in4, adc_in3, adc_in2, adc_in1};
        next_cur.adc_s2 = cur.adc_s1;

        // Pulses last one enabled cycle.
        next_cur.reply_valid  = 1'b0;
        next_cur.backup_valid = 1'b0;

        if (take) begin
            next_cur.reply_valid = 1'b1;
            next_cur.reply_code  = reply_ok;
            next_cur.reply_data  = '0;

            case (cmd_op)
                op_set_analog_output: begin
                    if (cmd_channel == `CH_DAC1) begin
                        next_cur.dac1_gp = clamp_dac(cmd_value);
                    end else if (cmd_channel == `CH_DAC2) begin
                        next_cur.dac2 = clamp_dac(cmd_value);
                    end else begin
                        next_cur.reply_code = reply_bad_dac;
                    end
                end

                op_read_analog_input: begin
                    // Any other channel number is refused with its own code.
                    if (cmd_channel >= `CH_ADC_FIRST
                            && cmd_channel <= `CH_ADC_LAST) begin
                        next_cur.reply_code = reply_value;
                        next_cur.reply_data = adc_word(cur.adc_s2, cmd_channel);
                    end else begin
                        next_cur.reply_code = reply_bad_adc;
                    end
                end

                op_set_center: begin
                    next_cur.center = cmd_value[`ADC_W-1:0];
                end

                op_set_dead_band: begin
                    next_cur.dead_band = cmd_value[`ADC_W-1:0];
                end

                op_set_range: begin
                    next_cur.range = cmd_value[`ADC_W-1:0];
                end

                op_set_max_speed: begin
                    next_cur.max_speed = cmd_value;
                end

                op_set_jog_source: begin
                    next_cur.jog_sel = cmd_value[`SEL_W-1:0];
                end

                op_query_settings: begin
                    // The settings ports carry the values during the reply.
                    next_cur.reply_code = reply_settings;
                end

                op_backup: begin
                    next_cur.backup_valid = 1'b1;
                end

                default: begin
                    // Unknown operations are dropped without a reply.
                    next_cur.reply_valid = 1'b0;
                end
            endcase
        end

        // The servo loop owns output 1 in servo mode; the written value waits.
        // Clamping here keeps a runaway loop value inside the converter span.
        if (servo_mode) begin
            next_cur.dac1_out = clamp_dac(servo_drive);
        end else begin
            next_cur.dac1_out = next_cur.dac1_gp;
        end

        // Stick jog runs only when selected and outside the dead band.
        // Direction is kept even inside the dead band, where it means nothing.
        next_cur.jog_active = stick_on & calc_moving;
        next_cur.jog_dir    = calc_dir;
        next_cur.jog_speed  = (stick_on & calc_moving) ? calc_speed : '0;
        next_cur.status     = (stick_on & calc_moving) ? status_stick
                                                       : status_idle;
    end

    // ----
    // State register
    // ----

    // The enable freezes every flop, the synchronisers included.
    // A frozen block also takes no command, since ready follows the enable.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= RST_STATE;
        end else if (clk_en) begin
            cur <= next_cur;
        end
    end

    // ----
    // Outputs
    // ----

    // All data outputs come straight from the state register.
    assign reply_valid         = cur.reply_valid;
    assign reply_code          = cur.reply_code;
    assign reply_data          = cur.reply_data;

    assign dac_out1            = cur.dac1_out;
    assign dac_out2            = cur.dac2;

    // Settings stand on their ports, which a query reply points to.
    assign stick_center_value  = cur.center;
    assign stick_dead_band     = cur.dead_band;
    assign stick_range_value   = cur.range;
    assign stick_max_speed     = cur.max_speed;
    assign jog_source_select   = cur.jog_sel;
    assign backup_to_flash_cmd = cur.backup_valid;

    // Jog and panel levels.
    assign jog_active          = cur.jog_active;
    assign jog_dir             = cur.jog_dir;
    assign jog_speed           = cur.jog_speed;
    assign status_code         = cur.status;

endmodule // joystick_jog_and_dac_output

// ==== dv/host_model.sv ====
// Host model: one command at a time, reply collected.
`timescale 1ns/1ns
`include "jog_defs.svh"
module host_model
    import jog_pkg::*;
(
    input  wire logic                 clk,
    input  wire logic                 cmd_ready,
    input  wire logic                 reply_valid,
    input  wire jog_pkg::reply_code_e reply_code,
    input  wire logic [`VAL_W-1:0]    reply_data,
    output logic                      cmd_valid,
    output jog_pkg::cmd_op_e          cmd_op,
    output logic [`CH_W-1:0]          cmd_channel,
    output logic signed [`VAL_W-1:0]  cmd_value
);
    // The request is low from time zero.
    initial cmd_valid = 1'b0;
    // Range from the full deflection reading, the threshold and the zero reading.
    function automatic int range_for(input int full, input int thr, input int zero);
        return full - 2 * thr - zero;
    endfunction
    // Request held to the taking edge; the reply is taken at the next falling edge.
    task automatic send(input cmd_op_e op, input int ch, input int v, output logic got,
                        output reply_code_e rc, output logic [`VAL_W-1:0] rd);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_op = op;
        cmd_channel = ch[3:0];
        cmd_value = v[15:0];
        @(posedge clk);
        while (!cmd_ready) @(posedge clk);
        @(negedge clk);
        got = reply_valid;
        rc = reply_code;
        rd = reply_data;
        cmd_valid = 1'b0;
    endtask
endmodule // host_model

// ==== dv/jog_monitor.sv ====
// Port-level assertions for the stick jog and analogue output block.
`timescale 1ns/1ns
`include "jog_defs.svh"
module jog_monitor
    import jog_pkg::*;
(
    input wire logic                     clk,
    input wire logic                     rst_n,
    input wire logic                     clk_en,
    input wire logic                     cmd_valid,
    input wire jog_pkg::cmd_op_e         cmd_op,
    input wire logic [`CH_W-1:0]         cmd_channel,
    input wire logic signed [`VAL_W-1:0] cmd_value,
    input wire logic                     reply_valid,
    input wire jog_pkg::reply_code_e     reply_code,
    input wire logic                     servo_mode,
    input wire logic signed [`VAL_W-1:0] servo_drive,
    input wire logic [`DAC_W-1:0]        dac_out1,
    input wire logic [`DAC_W-1:0]        dac_out2,
    input wire logic [`VAL_W-1:0]        stick_max_speed,
    input wire logic [`SEL_W-1:0]        jog_source_select,
    input wire logic                     backup_to_flash_cmd,
    input wire logic                     jog_active,
    input wire logic [`VAL_W-1:0]        jog_speed,
    input wire jog_pkg::status_e         status_code
);
    // ----
    // Helper terms
    // ----
    logic              take;
    logic              val_in;
    logic              srv_in;
    logic [`DAC_W-1:0] val12;
    logic [`DAC_W-1:0] srv12;
    // Commands count only on enabled edges.
    assign take   = cmd_valid && clk_en;
    assign val_in = cmd_value >= `DAC_NEG_MAX && cmd_value <= `DAC_POS_MAX;
    assign srv_in = servo_drive >= `DAC_NEG_MAX && servo_drive <= `DAC_POS_MAX;
    assign val12  = cmd_value[`DAC_W-1:0];
    assign srv12  = servo_drive[`DAC_W-1:0];
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ----
    // Assertions
    // ----
    reply_follows_cmd_a: assert property (
        take && cmd_op <= op_backup |=> reply_valid) else $error("command not answered");
    dac2_load_a: assert property (
        take && cmd_op == op_set_analog_output && cmd_channel == `CH_DAC2 && val_in
        |=> dac_out2 == $past(val12)) else $error("output 2 not loaded");
    // Output 1 may move under the servo loop, so only a stepper-mode span is held still.
    bad_dac_kept_a: assert property (
        take && cmd_op == op_set_analog_output && !(cmd_channel inside {`CH_DAC1, `CH_DAC2})
        |=> reply_code == reply_bad_dac && $stable(dac_out2)
        && ($past(servo_mode) || $past(servo_mode, 2) || $stable(dac_out1)))
        else $error("bad output channel mishandled");
    bad_adc_code_a: assert property (
        take && cmd_op == op_read_analog_input
        && (cmd_channel < `CH_ADC_FIRST || cmd_channel > `CH_ADC_LAST)
        |=> reply_code == reply_bad_adc) else $error("bad input channel not refused");
    servo_follow_a: assert property (
        clk_en && servo_mode && srv_in |=> dac_out1 == $past(srv12))
        else $error("output 1 not following servo");
    jog_gate_a: assert property (
        (!jog_source_select[`SEL_STICK]) [*3] |-> !jog_active)
        else $error("jog without stick source");
    status_code_a: assert property (
        status_code == (jog_active ? status_stick : status_idle))
        else $error("panel code disagrees with jog");
    speed_cap_a: assert property (
        jog_active && stick_max_speed == $past(stick_max_speed)
        && stick_max_speed == $past(stick_max_speed, 2) |-> jog_speed <= stick_max_speed)
        else $error("jog speed above maximum");
    backup_pulse_a: assert property (
        take && cmd_op == op_backup |=> backup_to_flash_cmd ##1 !backup_to_flash_cmd)
        else $error("backup pulse wrong");
    query_code_a: assert property (
        take && cmd_op == op_query_settings |=> reply_valid && reply_code == reply_settings)
        else $error("query reply wrong");
endmodule // jog_monitor

bind joystick_jog_and_dac_output jog_monitor i_mon (
    .clk, .rst_n, .clk_en, .cmd_valid, .cmd_op, .cmd_channel, .cmd_value, .reply_valid,
    .reply_code, .servo_mode, .servo_drive, .dac_out1, .dac_out2, .stick_max_speed,
    .jog_source_select, .backup_to_flash_cmd, .jog_active, .jog_speed, .status_code);

// ==== dv/joystick_jog_and_dac_output_tb.sv ====
// Self-checking bench for the stick jog and analogue output block.
`timescale 1ns/1ns
`include "jog_defs.svh"
module joystick_jog_and_dac_output_tb;
    import jog_pkg::*;
    // ----
    // Signals
    // ----
    logic                     clk = 1'b0;
    logic                     rst_n = 1'b0;
    logic                     clk_en = 1'b1;
    logic                     servo_mode = 1'b0;
    logic                     cmd_valid, cmd_ready, reply_valid, backup_to_flash_cmd, got;
    logic                     jog_active, jog_dir;
    cmd_op_e                  cmd_op;
    logic [`CH_W-1:0]         cmd_channel;
    logic signed [`VAL_W-1:0] cmd_value;
    logic signed [`VAL_W-1:0] servo_drive = 16'h0000;
    reply_code_e              reply_code, rc;
    logic [`VAL_W-1:0]        reply_data, rd, stick_max_speed, jog_speed;
    logic [`ADC_W-1:0]        adc [5] = '{default: 12'h000};
    logic [`DAC_W-1:0]        dac_out1, dac_out2;
    logic [`ADC_W-1:0]        stick_center_value, stick_dead_band, stick_range_value;
    logic [`SEL_W-1:0]        jog_source_select;
    status_e                  status_code;
    logic [31:0]              seed = 32'hA7EFDD68;
    int                       err_total = 0;
    int                       num_checks = 0;
    always #5 clk = ~clk;
    joystick_jog_and_dac_output i_dut (
        .clk, .rst_n, .clk_en, .cmd_valid, .cmd_ready, .cmd_op, .cmd_channel, .cmd_value,
        .reply_valid, .reply_code, .reply_data, .adc_in1(adc[0]), .adc_in2(adc[1]),
        .adc_in3(adc[2]), .adc_in4(adc[3]), .center_tap_input(adc[4]), .servo_mode,
        .servo_drive, .dac_out1, .dac_out2, .stick_center_value, .stick_dead_band,
        .stick_range_value, .stick_max_speed, .jog_source_select, .backup_to_flash_cmd,
        .jog_active, .jog_dir, .jog_speed, .status_code);
    host_model i_host (.clk, .cmd_ready, .reply_valid, .reply_code, .reply_data,
        .cmd_valid, .cmd_op, .cmd_channel, .cmd_value);
    // ----
    // Helpers
    // ----
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic int clamp(input int v);
        return v > `DAC_POS_MAX ? `DAC_POS_MAX : (v < `DAC_NEG_MAX ? `DAC_NEG_MAX : v);
    endfunction
    task automatic chk_val(input logic [15:0] g, input logic [15:0] e);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("Error at %0t: value %h, expected %h", $time, g, e);
        end
    endtask
    task automatic chk_code(input reply_code_e g, input reply_code_e e);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("Error at %0t: reply code %0d, expected %0d", $time, g, e);
        end
    endtask
    task automatic cmd(input cmd_op_e op, input int ch, input int v);
        i_host.send(op, ch, v, got, rc, rd);
        chk_val(16'(got), 16'h0001);
    endtask
    task automatic end_of_test();
        $display("Checks %0d, mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Limit far above the few hundred cycles of the run.
    initial begin
        #200000;
        err_total++;
        end_of_test();
    end
    // ----
    // Tests
    // ----
    initial begin
        int e1, e2, v, ref_v, dev, mag, band, rng, mx, ctr, stk, ch;
        logic act;
        int vals[6] = '{1024, -2047, 2047, -3000, 3000, -1};
        e1 = 0;
        e2 = 0;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        // Outputs: both channels, end values, saturation, bad channels.
        for (int i = 0; i < 26; i++) begin
            v = i < 6 ? vals[i] : int'(rnd() % 4095) - 2047;
            ch = i < 10 ? i % 2 + 1 : i - 10;
            cmd(op_set_analog_output, ch, v);
            if (ch == 1) e1 = clamp(v);
            if (ch == 2) e2 = clamp(v);
            chk_code(rc, ch == 1 || ch == 2 ? reply_ok : reply_bad_dac);
            chk_val(16'(dac_out1), 16'(e1 & 32'hFFF));
            chk_val(16'(dac_out2), 16'(e2 & 32'hFFF));
        end
        $display("Test analogue outputs done");
        // Servo mode: output 1 follows the loop; writes wait.
        servo_mode = 1'b1;
        for (int i = 0; i < 6; i++) begin
            v = i == 0 ? 3000 : int'(rnd() % 4095) - 2047;
            servo_drive = v[15:0];
            @(negedge clk);
            chk_val(16'(dac_out1), 16'(clamp(v) & 32'hFFF));
        end
        cmd(op_set_analog_output, 1, -700);
        chk_val(16'(dac_out1), 16'(clamp(v) & 32'hFFF));
        servo_mode = 1'b0;
        @(negedge clk);
        chk_val(16'(dac_out1), 16'h0D44);
        $display("Test servo output done");
        // Input readback over every channel number.
        for (int k = 0; k < 5; k++) adc[k] = 12'(rnd());
        repeat (4) @(negedge clk);
        for (int c = 0; c < 16; c++) begin
            cmd(op_read_analog_input, c, 0);
            if (c >= 1 && c <= 5) begin
                chk_code(rc, reply_value);
                chk_val(rd, c <= 2 ? {{4{adc[c-1][11]}}, adc[c-1]} : 16'(adc[c-1]));
            end else begin
                chk_code(rc, reply_bad_adc);
            end
        end
        cmd(op_query_settings, 0, 0);
        chk_code(rc, reply_settings);
        cmd(op_backup, 0, 0);
        chk_val(16'(backup_to_flash_cmd), 16'h0001);
        @(negedge clk);
        chk_val(16'(backup_to_flash_cmd), 16'h0000);
        i_host.send(cmd_op_e'(4'h9), 0, 0, got, rc, rd);
        chk_val(16'(got), 16'h0000);
        $display("Test readback and settings done");
        // Stick jog: dead band edges first, source off last.
        for (int i = 0; i < 12; i++) begin
            ctr = i % 2 ? 1950 + int'(rnd() % 200) : 0;
            adc[4] = 12'(1900 + rnd() % 300);
            adc[3] = 12'(rnd());
            band = i == 0 ? 25 : int'(rnd() % 200);
            rng = i == 0 ? i_host.range_for(2460, 25, 2051) : int'(rnd() % 700);
            mx = int'(rnd() % 65536);
            ref_v = ctr == 0 ? int'(adc[4]) : ctr;
            stk = i == 0 ? ref_v + band : (i == 1 ? ref_v - band - 1 : int'(rnd() % 4096));
            adc[2] = 12'(stk);
            cmd(op_set_center, 0, ctr);
            cmd(op_set_dead_band, 0, band);
            cmd(op_set_range, 0, rng);
            cmd(op_set_max_speed, 0, mx);
            cmd(op_set_jog_source, 0, i == 11 ? 0 : 'h20);
            chk_val(stick_max_speed, 16'(mx));
            chk_val(16'(stick_center_value), 16'(ctr));
            chk_val(16'(stick_dead_band), 16'(band));
            chk_val(16'(stick_range_value), 16'(rng));
            repeat (5) @(negedge clk);
            dev = stk - ref_v;
            mag = dev < 0 ? -dev : dev;
            act = mag > band && i != 11;
            chk_val(16'(jog_active), 16'(act));
            chk_val(16'(status_code), act ? 16'(status_stick) : 16'(status_idle));
            if (act) begin
                mag = mag - band;
                chk_val(16'(jog_dir), 16'(dev < 0));
                chk_val(jog_speed, 16'(rng == 0 || mag >= rng ? mx : mag * mx / rng));
            end
        end
        $display("Test stick jog done");
        end_of_test();
    end
endmodule // joystick_jog_and_dac_output_tb
